//--- hdl/gdio_pkg.sv
package gdio_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] GDIO_CTRL_OFS = 12'h000;
  localparam logic [11:0] GDIO_STAT_OFS = 12'h004;
  localparam logic [31:0] GDIO_CTRL_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int GDIO_CFG_W = 18;
  localparam int GDIO_IN_MODE_LSB = 0;
  localparam int GDIO_IN_FALL_BIT = 2;
  localparam int GDIO_IN_RESYNC_BIT = 3;
  localparam int GDIO_OUT_MODE_LSB = 4;
  localparam int GDIO_OUT_FALL_BIT = 6;
  localparam int GDIO_OUT_INV_BIT = 7;
  localparam int GDIO_OUT_RESYNC_BIT = 8;
  localparam int GDIO_OE_REG_BIT = 9;
  localparam int GDIO_OE_FALL_BIT = 10;
  localparam int GDIO_DIR_LSB = 11;
  localparam int GDIO_CTRL_NET_BIT = 13;
  localparam int GDIO_ALT_SEL_LSB = 14;
  localparam int GDIO_PULL_UP_BIT = 16;
  localparam int GDIO_PULL_DOWN_BIT = 17;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int GDIO_ST_PAD_BIT = 0;
  localparam int GDIO_ST_OE_BIT = 1;
  localparam int GDIO_ST_DIFF_BIT = 2;
  localparam int GDIO_ST_DDR_IN_BIT = 3;
  localparam int GDIO_ST_DDR_OUT_BIT = 4;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GDIO_REG_NONE,
    GDIO_REG_SINGLE,
    GDIO_REG_DOUBLE
  } gdio_reg_mode_t;

  typedef enum logic [1:0] {
    GDIO_DIR_INPUT,
    GDIO_DIR_OUTPUT,
    GDIO_DIR_BIDIR
  } gdio_dir_t;

  typedef enum logic [1:0] {
    GDIO_ALT_CLOCK_NET,
    GDIO_ALT_CONTROL_NET,
    GDIO_ALT_SYNTH_REF,
    GDIO_ALT_CAMERA_REF
  } gdio_alt_sel_t;

endpackage

//--- hdl/gdio_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module gdio_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // ----------------------------------------------------------------
  // Two-stage synchroniser, one per bit
  // ----------------------------------------------------------------
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    // First stage read only by the second
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        meta[i] <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta[i] <= d[i];
        q[i] <= meta[i];
      end
    end
  end

endmodule
`default_nettype wire

//--- hdl/gdio_io_logic.sv
// Contract
// - Single-rate input delivers pad data on the rise sample bit only.
// - Double-rate input puts the rising sample on the rise bit and the falling sample on the fall bit.
// - Double-rate output drives the rise bit and then the fall bit onto the pad as one stream.
// - With no input register the pad feeds an alternate path to clock, control or reference clock nets.
// - In bidirectional mode the core output enable reaches the pad buffer, optionally through a register.
// - Output data and output-enable registers run on the egress clock.
// - Input data registers run on a separate ingress clock.
// - Double-rate mode samples on both edges and exchanges two bits per cycle with the core.
// - Normal double-rate passes each bit on the edge where it was handled.
// - Resync double-rate realigns both bits to the rising edge for the core.
// - Resync input delays the falling sample half a cycle to join the next rising sample.
// - A pin on differential-pair resources has no double-rate mode and no pull-down.
// - A pin may be set up as a control input feeding the high-fanout control network.
// - Input-only mode enables only the input path, registrable on either edge.
// - The output register may be inverted in output-only and bidirectional modes.
// - Bidirectional mode allows either edge on every register, input and output registered independently.
`timescale 1ns/1ps
`default_nettype none
module gdio_io_logic
  import gdio_pkg::*;
#(
  parameter bit DIFF_PAIR_PIN = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ingress_reg_clock,
  input wire logic egress_reg_clock,
  output logic rise_sample_bit,
  output logic fall_sample_bit,
  input wire logic rise_drive_bit,
  input wire logic fall_drive_bit,
  input wire logic core_oe,
  output logic alternate_unreg_input,
  output logic global_clock_net,
  output logic global_control_net,
  output logic synth_ref_clock_in,
  output logic camera_phy_ref_clock_in,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_pull_up,
  output logic pad_pull_down
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Double rate falls back to single rate on differential-pair pins
  function automatic gdio_reg_mode_t reg_mode(input logic [1:0] f);
    gdio_reg_mode_t m;
    m = GDIO_REG_NONE;
    if (f == 2'd1) begin
      m = GDIO_REG_SINGLE;
    end else if (f == 2'd2) begin
      m = DIFF_PAIR_PIN ? GDIO_REG_SINGLE : GDIO_REG_DOUBLE;
    end
    return m;
  endfunction

  function automatic gdio_dir_t dir_mode(input logic [1:0] f);
    gdio_dir_t d;
    d = GDIO_DIR_INPUT;
    if (f == 2'd1) begin
      d = GDIO_DIR_OUTPUT;
    end else if (f == 2'd2) begin
      d = GDIO_DIR_BIDIR;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Two registers only: control at the first word, status at the next.
  // The bus never stalls, so every transfer is a setup cycle and one
  // access cycle. Read data is loaded in the setup cycle, which lets
  // prdata come straight from a flop instead of a wide comb mux.
  // Writes to status are dropped quietly; only unmapped words error.
  logic [31:0] ctrl;
  logic [31:0] status;
  logic [1:0] stat_sync;
  logic wr_ctrl;
  logic hit;

  assign hit = (paddr == GDIO_CTRL_OFS) || (paddr == GDIO_STAT_OFS);
  assign wr_ctrl = psel && penable && pwrite && (paddr == GDIO_CTRL_OFS);
  // Zero wait states; unmapped addresses error out
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Control register, only implemented bits kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= GDIO_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= {{(32 - GDIO_CFG_W){1'b0}}, pwdata[GDIO_CFG_W-1:0]};
    end
  end

  // Live status, pad level and driver state seen from bus clock
  always_comb begin
    status = 32'h0000_0000;
    status[GDIO_ST_PAD_BIT] = stat_sync[0];
    status[GDIO_ST_OE_BIT] = stat_sync[1];
    status[GDIO_ST_DIFF_BIT] = DIFF_PAIR_PIN;
    status[GDIO_ST_DDR_IN_BIT] = reg_mode(ctrl[GDIO_IN_MODE_LSB +: 2]) == GDIO_REG_DOUBLE;
    status[GDIO_ST_DDR_OUT_BIT] = reg_mode(ctrl[GDIO_OUT_MODE_LSB +: 2]) == GDIO_REG_DOUBLE;
  end

  // Read data registered in the setup cycle, valid in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == GDIO_CTRL_OFS) begin
        prdata <= ctrl;
      end else if (paddr == GDIO_STAT_OFS) begin
        prdata <= status;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration into the I/O clock domains
  // ----------------------------------------------------------------
  // Settings are quasi-static; change them only with the pin idle
  // Each bit is synced on its own, so a multi-bit change can land
  // over two edges and show a mixed mode for one cycle. That is the
  // price of skipping a handshake on a word that almost never moves.
  // Bits that only steer comb paths (alt routing) stay on the bus clock.
  logic [GDIO_CFG_W-1:0] icfg;
  logic [GDIO_CFG_W-1:0] ocfg;

  gdio_sync2 #(.W(GDIO_CFG_W)) u_icfg (
    .clk(ingress_reg_clock),
    .rst_n(presetn),
    .d(ctrl[GDIO_CFG_W-1:0]),
    .q(icfg)
  );

  gdio_sync2 #(.W(GDIO_CFG_W)) u_ocfg (
    .clk(egress_reg_clock),
    .rst_n(presetn),
    .d(ctrl[GDIO_CFG_W-1:0]),
    .q(ocfg)
  );

  gdio_sync2 #(.W(2)) u_stat (
    .clk(pclk),
    .rst_n(presetn),
    .d({pad_oe, pad_in}),
    .q(stat_sync)
  );

  gdio_reg_mode_t in_mode;
  gdio_reg_mode_t out_mode;
  gdio_dir_t i_dir;
  gdio_dir_t o_dir;
  gdio_dir_t p_dir;
  gdio_alt_sel_t alt_sel;
  logic in_en;

  assign in_mode = reg_mode(icfg[GDIO_IN_MODE_LSB +: 2]);
  assign out_mode = reg_mode(ocfg[GDIO_OUT_MODE_LSB +: 2]);
  assign i_dir = dir_mode(icfg[GDIO_DIR_LSB +: 2]);
  assign o_dir = dir_mode(ocfg[GDIO_DIR_LSB +: 2]);
  assign p_dir = dir_mode(ctrl[GDIO_DIR_LSB +: 2]);
  assign alt_sel = gdio_alt_sel_t'(ctrl[GDIO_ALT_SEL_LSB +: 2]);
  // Input path dead in output-only mode
  assign in_en = (i_dir != GDIO_DIR_OUTPUT);

  // ----------------------------------------------------------------
  // Input path, ingress clock
  // ----------------------------------------------------------------
  // The pad is the data being captured, so it is not synchronised here;
  // the core owns the ingress clock and must meet setup at the pad.
  // Both capture flops run all the time; the mode only picks outputs.
  logic in_pos;
  logic in_neg;
  logic in_neg_rs;

  // Rising-edge capture, also resync stage for the falling sample
  always_ff @(posedge ingress_reg_clock or negedge presetn) begin
    if (!presetn) begin
      in_pos <= 1'b0;
      in_neg_rs <= 1'b0;
    end else begin
      in_pos <= pad_in;
      in_neg_rs <= in_neg;
    end
  end

  // Falling-edge capture for double rate or falling single rate
  always_ff @(negedge ingress_reg_clock or negedge presetn) begin
    if (!presetn) begin
      in_neg <= 1'b0;
    end else begin
      in_neg <= pad_in;
    end
  end

  // Core-facing input bits
  always_comb begin
    rise_sample_bit = 1'b0;
    fall_sample_bit = 1'b0;
    if (in_en) begin
      unique case (in_mode)
        GDIO_REG_NONE: begin
          rise_sample_bit = pad_in;
        end
        GDIO_REG_SINGLE: begin
          // Fall bit stays low in single rate
          rise_sample_bit = icfg[GDIO_IN_FALL_BIT] ? in_neg : in_pos;
        end
        GDIO_REG_DOUBLE: begin
          rise_sample_bit = in_pos;
          fall_sample_bit = icfg[GDIO_IN_RESYNC_BIT] ? in_neg_rs : in_neg;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Alternate and control-network inputs
  // ----------------------------------------------------------------
  // Unregistered pad level; only offered with no input register
  logic alt_on;
  assign alt_on = (p_dir != GDIO_DIR_OUTPUT) && (reg_mode(ctrl[GDIO_IN_MODE_LSB +: 2]) == GDIO_REG_NONE);
  assign alternate_unreg_input = alt_on ? pad_in : 1'b0;
  assign global_clock_net = alt_on && (alt_sel == GDIO_ALT_CLOCK_NET) && pad_in;
  assign global_control_net = alt_on && (ctrl[GDIO_CTRL_NET_BIT] || alt_sel == GDIO_ALT_CONTROL_NET)
    && pad_in;
  assign synth_ref_clock_in = alt_on && (alt_sel == GDIO_ALT_SYNTH_REF) && pad_in;
  assign camera_phy_ref_clock_in = alt_on && (alt_sel == GDIO_ALT_CAMERA_REF) && pad_in;

  // ----------------------------------------------------------------
  // Output and output-enable path, egress clock
  // ----------------------------------------------------------------
  // Double rate muxes on the egress clock level itself, so the pad
  // shows the rise flop while the clock is high and the fall flop
  // while it is low. Resync takes the fall bit at the rising edge
  // and holds it for the following low phase.
  logic inv;
  logic out_pos;
  logic out_neg;
  logic fall_hold;
  logic oe_pos;
  logic oe_neg;
  logic oe_eff;
  logic data_eff;

  assign inv = ocfg[GDIO_OUT_INV_BIT];

  // Rising-edge data, OE, and resync hold of the fall bit
  always_ff @(posedge egress_reg_clock or negedge presetn) begin
    if (!presetn) begin
      out_pos <= 1'b0;
      fall_hold <= 1'b0;
      oe_pos <= 1'b0;
    end else begin
      out_pos <= rise_drive_bit ^ inv;
      fall_hold <= fall_drive_bit ^ inv;
      oe_pos <= core_oe;
    end
  end

  // Falling-edge data and OE; resync takes the bit held at the rise
  always_ff @(negedge egress_reg_clock or negedge presetn) begin
    if (!presetn) begin
      out_neg <= 1'b0;
      oe_neg <= 1'b0;
    end else begin
      if (out_mode == GDIO_REG_DOUBLE) begin
        out_neg <= ocfg[GDIO_OUT_RESYNC_BIT] ? fall_hold : (fall_drive_bit ^ inv);
      end else begin
        out_neg <= rise_drive_bit ^ inv;
      end
      oe_neg <= core_oe;
    end
  end

  // Pad data select; double rate muxes on the clock phase
  always_comb begin
    data_eff = rise_drive_bit ^ inv;
    unique case (out_mode)
      GDIO_REG_NONE: begin
        data_eff = rise_drive_bit ^ inv;
      end
      GDIO_REG_SINGLE: begin
        data_eff = ocfg[GDIO_OUT_FALL_BIT] ? out_neg : out_pos;
      end
      GDIO_REG_DOUBLE: begin
        data_eff = egress_reg_clock ? out_pos : out_neg;
      end
    endcase
  end

  // Effective OE by direction; output-only drives constantly
  always_comb begin
    oe_eff = 1'b0;
    unique case (o_dir)
      GDIO_DIR_INPUT: begin
        oe_eff = 1'b0;
      end
      GDIO_DIR_OUTPUT: begin
        oe_eff = 1'b1;
      end
      GDIO_DIR_BIDIR: begin
        if (ocfg[GDIO_OE_REG_BIT]) begin
          oe_eff = ocfg[GDIO_OE_FALL_BIT] ? oe_neg : oe_pos;
        end else begin
          oe_eff = core_oe;
        end
      end
    endcase
  end

  // Released driver shows low data so the pad is input only
  assign pad_oe = oe_eff;
  assign pad_out = oe_eff ? data_eff : 1'b0;

  // ----------------------------------------------------------------
  // Pull controls
  // ----------------------------------------------------------------
  assign pad_pull_up = ctrl[GDIO_PULL_UP_BIT];
  assign pad_pull_down = ctrl[GDIO_PULL_DOWN_BIT] && !DIFF_PAIR_PIN;

endmodule
`default_nettype wire

//--- tb/gdio_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Pad wire with a far-side driver
// ----------------------------------------
module gdio_pad_model (
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pad_pull_up,
  input wire logic pad_pull_down,
  input wire logic ext_en,
  input wire logic ext_val,
  output logic pad_in
);
  // Pin driver first; a released pad never keeps a stale level by luck
  always_comb begin
    if (pad_oe) pad_in = pad_out;
    else if (ext_en) pad_in = ext_val;
    else if (pad_pull_up) pad_in = 1'b1;
    else if (pad_pull_down) pad_in = 1'b0;
    else pad_in = ~ext_val;
  end
endmodule
`default_nettype wire

//--- tb/gdio_io_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module gdio_io_checker
  import gdio_pkg::*;
#(
  parameter bit DIFF_PAIR_PIN = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pad_in,
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pad_pull_down,
  input wire logic alternate_unreg_input
);
  logic [17:0] ctrl_q;
  logic [4:0] quiet;
  logic acc;
  assign acc = psel && penable;
  // Shadow control word; pin domains lag it, so pin checks wait for quiet
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      quiet <= '0;
    end else if (acc && pwrite && paddr == GDIO_CTRL_OFS) begin
      ctrl_q <= pwdata[17:0];
      quiet <= '0;
    end else if (quiet != 5'h1f) begin
      quiet <= quiet + 5'h01;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_high_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> acc) else $error("error outside access");
  err_map_a: assert property (acc && paddr != GDIO_CTRL_OFS && paddr != GDIO_STAT_OFS
    |-> pslverr && prdata == 32'h0000_0000) else $error("unmapped access not refused");
  ctrl_read_a: assert property (acc && !pwrite && paddr == GDIO_CTRL_OFS |-> prdata == {14'h0000, ctrl_q})
    else $error("control readback wrong");
  stat_diff_a: assert property (acc && !pwrite && paddr == GDIO_STAT_OFS
    |-> prdata[GDIO_ST_DIFF_BIT] == DIFF_PAIR_PIN) else $error("pin kind wrong");
  pull_down_a: assert property (##1 pad_pull_down == (ctrl_q[GDIO_PULL_DOWN_BIT] && !DIFF_PAIR_PIN))
    else $error("pull-down wrong");
  oe_release_a: assert property (!pad_oe |-> !pad_out) else $error("data while released");
  oe_input_a: assert property (quiet[4] && ctrl_q[12:11] inside {2'h0, 2'h3} |-> !pad_oe)
    else $error("input pin drives");
  oe_output_a: assert property (quiet[4] && ctrl_q[12:11] == 2'h1 |-> pad_oe)
    else $error("output pin released");
  alt_path_a: assert property (quiet[4] && ctrl_q[1:0] inside {2'h0, 2'h3} && ctrl_q[12:11] != 2'h1
    |-> alternate_unreg_input == pad_in) else $error("alternate path wrong");
  cover property (acc && pslverr);
  cover property (acc && pwrite && paddr == GDIO_CTRL_OFS);
  cover property (pad_oe && pad_out);
endmodule
bind gdio_io_logic gdio_io_checker #(.DIFF_PAIR_PIN(DIFF_PAIR_PIN)) chk_u (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe,
  .pad_pull_down, .alternate_unreg_input);
`default_nettype wire

//--- tb/gdio_io_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Pin logic bench
// ----------------------------------------
module gdio_io_logic_tb;
  import gdio_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic ingress_reg_clock, egress_reg_clock, rise_sample_bit, fall_sample_bit;
  logic rise_drive_bit, fall_drive_bit, core_oe, alternate_unreg_input, global_clock_net;
  logic global_control_net, synth_ref_clock_in, camera_phy_ref_clock_in;
  logic pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, ext_en, ext_val, err;
  logic a, a0, b, rp, fp, op, hi, lo;
  logic [15:0] lf;
  logic [3:0] nets;
  int failures, n_compared, cyc;
  localparam logic [31:0] IN_CFG [4] = '{32'h0000_0001, 32'h0000_0005, 32'h0000_0002, 32'h0000_000a};
  localparam logic [31:0] OUT_CFG [4] = '{32'h0000_0820, 32'h0000_08a0, 32'h0000_0810, 32'h0000_1320};
  assign nets = {camera_phy_ref_clock_in, synth_ref_clock_in, global_control_net, global_clock_net};
  gdio_io_logic dut_u (.*);
  gdio_pad_model pad_u (.pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pull_up),
    .pad_pull_down(pad_pull_down), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
  // Three unrelated clocks; the pin clocks run through reset too
  initial begin pclk = 1'b0; forever #12.5 pclk = ~pclk; end
  initial begin ingress_reg_clock = 1'b0; #3; forever #10 ingress_reg_clock = ~ingress_reg_clock; end
  initial begin egress_reg_clock = 1'b0; #7; forever #15 egress_reg_clock = ~egress_reg_clock; end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Pad level expected while the egress clock is low
  function automatic logic low_exp(input int k, input logic r_old, f_old, f_new);
    return (k == 2) ? r_old : ((k == 3) ? f_old : f_new);
  endfunction
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Request held until pready is seen high at an edge
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Far side changes the pad each half cycle of the ingress clock
  task in_run(input int k);
    apb(1'b1, GDIO_CTRL_OFS, IN_CFG[k]);
    a = 1'b0;
    b = 1'b0;
    ext_val <= 1'b0;
    repeat (6) @(posedge ingress_reg_clock);
    for (int i = 0; i < 16; i++) begin
      @(posedge ingress_reg_clock);
      if (k == 1) chk("rise bit fall edge", a, rise_sample_bit);
      if (k == 2) chk("fall bit", a, fall_sample_bit);
      a0 = a;
      lf = lfsr_next(lf);
      a = lf[0];
      ext_val <= a;
      @(negedge ingress_reg_clock);
      if (k != 1) chk("rise bit", b, rise_sample_bit);
      if (k < 2) chk("fall bit idle", 1'b0, fall_sample_bit);
      if (k == 3) chk("resync fall bit", a0, fall_sample_bit);
      b = lf[1];
      ext_val <= b;
    end
  endtask
  // Core side hands both bits and the enable at each rising edge
  task out_run(input int k);
    apb(1'b1, GDIO_CTRL_OFS, OUT_CFG[k]);
    repeat (6) @(posedge egress_reg_clock);
    for (int i = 0; i < 16; i++) begin
      @(posedge egress_reg_clock);
      rp = rise_drive_bit;
      fp = fall_drive_bit;
      op = (k == 3) ? core_oe : 1'b1;
      lf = lfsr_next(lf);
      rise_drive_bit <= lf[0];
      fall_drive_bit <= lf[1];
      core_oe <= lf[2];
      #7;
      hi = op & (rp ^ (k == 1));
      chk("pad oe", op, pad_oe);
      chk("pad high half", hi, pad_out);
      @(negedge egress_reg_clock);
      #7;
      lo = op & (low_exp(k, rp, fp, lf[1]) ^ (k == 1));
      chk("pad low half", lo, pad_out);
    end
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {rise_drive_bit, fall_drive_bit, core_oe, ext_val} = '0;
    ext_en = 1'b1;
    lf = 16'ha6ad;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, GDIO_CTRL_OFS, 32'h0000_0000);
    chk("ctrl reset", GDIO_CTRL_RST, rd);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, err});
    apb(1'b0, GDIO_STAT_OFS, 32'h0000_0000);
    chk("status pin kind", 32'h0000_0000, {31'h0000_0000, rd[GDIO_ST_DIFF_BIT]});
    lf = lfsr_next(lf);
    apb(1'b1, GDIO_CTRL_OFS, {14'h0000, lf[1:0], lf});
    apb(1'b0, GDIO_CTRL_OFS, 32'h0000_0000);
    chk("ctrl readback", {14'h0000, lf[1:0], lf}, rd);
    chk("pull up", lf[0], pad_pull_up);
    chk("pull down", lf[1], pad_pull_down);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, GDIO_CTRL_OFS, 32'(s) << 14);
      ext_val <= s[0];
      repeat (4) @(posedge ingress_reg_clock);
      chk("alt net", ext_val, nets[s]);
      chk("alt input", ext_val, alternate_unreg_input);
    end
    apb(1'b1, GDIO_CTRL_OFS, 32'h0000_2000);
    ext_val <= 1'b1;
    repeat (4) @(posedge ingress_reg_clock);
    chk("control input", 1'b1, global_control_net);
    for (int k = 0; k < 4; k++) in_run(k);
    for (int k = 0; k < 4; k++) out_run(k);
    // Last mode is double-rate output with unregistered input
    apb(1'b0, GDIO_STAT_OFS, 32'h0000_0000);
    chk("status double out", 32'h0000_0001, {31'h0000_0000, rd[GDIO_ST_DDR_OUT_BIT]});
    chk("status double in", 32'h0000_0000, {31'h0000_0000, rd[GDIO_ST_DDR_IN_BIT]});
    give_verdict();
  end
endmodule
`default_nettype wire
